// ---- pkg/pms_params.svh ----
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// Register indices on the management link.
`define PMS_REG_BCTL 5'h00
`define PMS_REG_ADV  5'h04
`define PMS_REG_GIG  5'h09
`define PMS_REG_EXT  5'h13

// Reset values before the mode defaults are applied.
`define PMS_BCTL_RST 16'h0000
`define PMS_ADV_RST  16'h01E1
`define PMS_GIG_RST  16'h0300
`define PMS_LAMP_RST 2'h3

// Field positions.
`define PMS_BC_SRST  15
`define PMS_BC_SPD0  13
`define PMS_BC_ANEN  12
`define PMS_BC_DUP   8
`define PMS_BC_SPD1  6
`define PMS_ADV_LO   5
`define PMS_GIG_LO   8
`define PMS_EXT_OPM  11
`define PMS_EXT_LAMP 6
`define PMS_EXT_MCO  3

// Timing.
`define PMS_CLK_MHZ       100
`define PMS_BLINK_HALF_MS 50
`define PMS_SETTLE_CYC    4'h4
`define PMS_MDIO_PRE      6'h20

`endif

// ---- pkg/pms_pkg.sv ----
package pms_pkg;

  typedef enum logic [1:0] {
    PMS_SPD_10,
    PMS_SPD_100,
    PMS_SPD_1000
  } pms_speed_e;

  typedef enum logic [1:0] {
    PMS_ST_SETTLE,
    PMS_ST_LATCH,
    PMS_ST_APPLY,
    PMS_ST_RUN
  } pms_state_e;

  typedef struct packed {
    logic gig;
    logic fast;
    logic slow;
    logic act;
  } pms_lamp_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] data;
  } pms_mreq_s;

endpackage : pms_pkg

// ---- logic/pms_sync.sv ----
module pms_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i, // System clock.
  input  wire logic             srst_i,    // Synchronous reset.
  input  wire logic [WIDTH-1:0] d_i,       // Asynchronous inputs.
  output logic      [WIDTH-1:0] q_o        // Filtered, synchronous.
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once the second and third stages agree.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        q_o[i] <= 1'b0;
      end else if (s2_ff[i] == s3_ff[i]) begin
        q_o[i] <= s3_ff[i];
      end
    end
  end

endmodule : pms_sync

// ---- logic/pms_mdio_slave.sv ----
`include "pms_params.svh"

module pms_mdio_slave import pms_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic        clk_sys_i, // System clock.
  input  wire logic        srst_i,    // Synchronous reset.
  input  wire logic        mdc_i,     // Synchronised management clock.
  input  wire logic        mdio_i,    // Synchronised data in.
  input  wire logic [15:0] rd_data_i, // Register read data.
  output pms_mreq_s        req_o,     // Access strobes.
  output logic             mdio_o,    // Data out.
  output logic             mdio_oe_o  // Data drive enable.
);

  logic       mdc_q_ff;
  logic [5:0] pre_ff;
  logic [5:0] bit_ff;
  logic       act_ff;
  logic       hit_ff;
  logic       rdop_ff;
  logic [15:0] sh_ff;
  logic [15:0] osh_ff;
  logic [13:0] hdr;
  logic       rise;

  assign rise = mdc_i & ~mdc_q_ff;
  assign hdr  = {sh_ff[12:0], mdio_i};

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mdc_q_ff <= 1'b0;
      pre_ff   <= '0;
      bit_ff   <= '0;
      act_ff   <= 1'b0;
      hit_ff   <= 1'b0;
      rdop_ff  <= 1'b0;
      sh_ff    <= '0;
      req_o    <= '0;
    end else begin
      mdc_q_ff  <= mdc_i;
      req_o.wr  <= 1'b0;
      req_o.rd  <= 1'b0;
      if (rise) begin
        sh_ff <= {sh_ff[14:0], mdio_i};
        if (!act_ff) begin
          pre_ff <= !mdio_i ? 6'h00 : (pre_ff == `PMS_MDIO_PRE) ? pre_ff : pre_ff + 6'h01;
          if (!mdio_i && pre_ff == `PMS_MDIO_PRE) begin
            act_ff <= 1'b1;
            bit_ff <= 6'h01;
          end
        end else begin
          bit_ff <= bit_ff + 6'h01;
          if (bit_ff == 6'h0D) begin
            hit_ff     <= hdr[13:12] == 2'h1 && hdr[9:5] == PHY_ADDR && (hdr[11:10] == 2'h2 || hdr[11:10] == 2'h1);
            rdop_ff    <= hdr[11:10] == 2'h2;
            req_o.addr <= hdr[4:0];
            req_o.rd   <= hdr[13:12] == 2'h1 && hdr[9:5] == PHY_ADDR && hdr[11:10] == 2'h2;
          end
          if (bit_ff == 6'h1F) begin
            act_ff   <= 1'b0;
            pre_ff   <= 6'h00;
            req_o.wr <= hit_ff & ~rdop_ff;
            req_o.data <= {sh_ff[14:0], mdio_i};
          end
        end
      end
    end
  end

  // Read data leaves on the clock rise so the manager samples it one rise later.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mdio_o    <= 1'b1;
      mdio_oe_o <= 1'b0;
      osh_ff    <= '0;
    end else if (rise && act_ff && hit_ff && rdop_ff) begin
      if (bit_ff == 6'h0E) begin
        mdio_o    <= 1'b0;
        mdio_oe_o <= 1'b1;
        osh_ff    <= rd_data_i;
      end else if (bit_ff == 6'h1F) begin
        mdio_o    <= 1'b1;
        mdio_oe_o <= 1'b0;
      end else begin
        mdio_o <= osh_ff[15];
        osh_ff <= {osh_ff[14:0], 1'b0};
      end
    end
  end

endmodule : pms_mdio_slave

// ---- logic/pms_mode_lamp_ctl.sv ----
`include "pms_params.svh"

module pms_mode_lamp_ctl import pms_pkg::*; #(
  parameter logic [4:0] PHY_ADDR  = 5'h00,
  parameter int         BLINK_CYC = `PMS_BLINK_HALF_MS * 1000 * `PMS_CLK_MHZ
) (
  input  wire logic        clk_sys_i,       // System clock, 100 MHz.
  input  wire logic        srst_i,          // Synchronous reset.
  input  wire logic [1:0]  mode_pin_hi_i,   // Upper mode pin code.
  input  wire logic [1:0]  mode_pin_lo_i,   // Lower mode pin code.
  input  wire logic        mdc_i,           // Management clock pin.
  input  wire logic        mdio_i,          // Management data in.
  output logic             mdio_o,          // Management data out.
  output logic             mdio_oe_o,       // Management drive enable.
  input  wire logic        link_up_i,       // Link established.
  input  wire pms_speed_e  speed_i,         // Resolved link speed.
  input  wire logic        duplex_done_i,   // Duplex resolved.
  input  wire logic        full_duplex_i,   // Full duplex resolved.
  input  wire logic        activity_i,      // Transmit or receive.
  input  wire logic        collision_i,     // Collision seen.
  output pms_lamp_s        lamp_o,          // Lamp levels.
  output pms_lamp_s        lamp_oe_o,       // Lamp drive enables.
  output logic [15:0]      bctl_o,          // Basic control.
  output logic [15:0]      adv_o,           // Advertisement.
  output logic [15:0]      gig_o,           // Gigabit control.
  output logic             mac_clock_off_o, // Mac clock disabled.
  output logic             cfg_done_o       // Defaults applied.
);

  logic [5:0]  pins;
  logic [1:0]  pin_hi;
  logic [1:0]  pin_lo;
  logic        mdc_s;
  logic        mdio_s;
  pms_mreq_s   req;
  logic [15:0] rd_data_ff;
  pms_state_e  st_ff;
  logic [3:0]  settle_ff;
  logic [15:0] bctl_ff;
  logic [15:0] adv_ff;
  logic [15:0] gig_ff;
  logic [4:0]  op_mode_field_ff;
  logic        mco_ff;
  logic [1:0]  lamp_scheme_ff;
  logic [31:0] blink_cnt_ff;
  logic        blink_ff;
  pms_lamp_s   nxt_lamp;
  pms_lamp_s   nxt_oe;
  logic        is10;
  logic        is100;
  logic        is1000;

  // Pins and the management clock come from outside the clock domain.
  pms_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .d_i       ({mode_pin_hi_i, mode_pin_lo_i, mdc_i, mdio_i}),
    .q_o       (pins)
  );

  assign pin_hi = pins[5:4];
  assign pin_lo = pins[3:2];
  assign mdc_s  = pins[1];
  assign mdio_s = pins[0];

  pms_mdio_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .mdc_i     (mdc_s),
    .mdio_i    (mdio_s),
    .rd_data_i (rd_data_ff),
    .req_o     (req),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o)
  );

  // Pin codes to operating mode; bit 0 of the upper code picks the table.
  function automatic logic [4:0] mode_of(input logic [1:0] hi, input logic [1:0] lo);
    logic [4:0] m;
    m = {3'h0, lo};
    if (hi[0]) begin
      unique case (lo)
        2'h0: m = 5'h07;
        2'h1: m = 5'h04;
        2'h2: m = 5'h09;
        2'h3: m = 5'h0A;
      endcase
    end
    return m;
  endfunction : mode_of

  // Settle waits for the pin filter before latching the board codes.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff     <= PMS_ST_SETTLE;
      settle_ff <= 4'h0;
    end else begin
      unique case (st_ff)
        PMS_ST_SETTLE: begin
          settle_ff <= settle_ff + 4'h1;
          if (settle_ff == `PMS_SETTLE_CYC) begin
            st_ff <= PMS_ST_LATCH;
          end
        end
        PMS_ST_LATCH: st_ff <= PMS_ST_APPLY;
        PMS_ST_APPLY: st_ff <= PMS_ST_RUN;
        PMS_ST_RUN:   st_ff <= PMS_ST_RUN;
      endcase
    end
  end

  // Register file. A soft reset only self-clears; nothing relatches.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bctl_ff          <= `PMS_BCTL_RST;
      adv_ff           <= `PMS_ADV_RST;
      gig_ff           <= `PMS_GIG_RST;
      op_mode_field_ff <= 5'h00;
      mco_ff           <= 1'b0;
      lamp_scheme_ff   <= `PMS_LAMP_RST;
    end else if (st_ff == PMS_ST_LATCH) begin
      op_mode_field_ff <= mode_of(pin_hi, pin_lo);
      mco_ff           <= pin_hi[1];
    end else if (st_ff == PMS_ST_APPLY) begin
      if (op_mode_field_ff[4:2] == 3'h0) begin
        bctl_ff[`PMS_BC_SPD0] <= op_mode_field_ff[1];
        bctl_ff[`PMS_BC_ANEN] <= 1'b0;
        bctl_ff[`PMS_BC_DUP]  <= op_mode_field_ff[0];
        bctl_ff[`PMS_BC_SPD1] <= 1'b0;
        gig_ff[`PMS_GIG_LO+1 -: 2] <= 2'h0;
      end else if (op_mode_field_ff == 5'h04) begin
        bctl_ff[`PMS_BC_SPD0] <= 1'b1;
        bctl_ff[`PMS_BC_ANEN] <= 1'b1;
        bctl_ff[`PMS_BC_DUP]  <= 1'b0;
        bctl_ff[`PMS_BC_SPD1] <= 1'b0;
        adv_ff[`PMS_ADV_LO+3 -: 4] <= 4'h4;
        gig_ff[`PMS_GIG_LO+1 -: 2] <= 2'h0;
      end else if (op_mode_field_ff == 5'h07 || op_mode_field_ff == 5'h09 ||
                   op_mode_field_ff == 5'h0A) begin
        bctl_ff[`PMS_BC_SPD0] <= 1'b0;
        bctl_ff[`PMS_BC_ANEN] <= 1'b1;
        bctl_ff[`PMS_BC_SPD1] <= 1'b1;
        adv_ff[`PMS_ADV_LO+3 -: 4] <= 4'hF;
        gig_ff[`PMS_GIG_LO+4 -: 5] <= (op_mode_field_ff == 5'h07) ? 5'h03 :
                                      (op_mode_field_ff == 5'h09) ? 5'h13 : 5'h1F;
      end
    end else begin
      bctl_ff[`PMS_BC_SRST] <= 1'b0;
      if (req.wr) begin
        unique case (req.addr)
          `PMS_REG_BCTL: bctl_ff <= req.data;
          `PMS_REG_ADV:  adv_ff  <= req.data;
          `PMS_REG_GIG:  gig_ff  <= req.data;
          `PMS_REG_EXT: begin
            op_mode_field_ff <= req.data[`PMS_EXT_OPM+4 -: 5];
            lamp_scheme_ff   <= req.data[`PMS_EXT_LAMP+1 -: 2];
            mco_ff           <= req.data[`PMS_EXT_MCO];
          end
          default: ;
        endcase
      end
    end
  end

  // Read data is captured at the request and held through the frame.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_data_ff <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        `PMS_REG_BCTL: rd_data_ff <= bctl_ff;
        `PMS_REG_ADV:  rd_data_ff <= adv_ff;
        `PMS_REG_GIG:  rd_data_ff <= gig_ff;
        `PMS_REG_EXT: begin
          rd_data_ff <= 16'h0000;
          rd_data_ff[`PMS_EXT_OPM+4 -: 5]  <= op_mode_field_ff;
          rd_data_ff[`PMS_EXT_LAMP+1 -: 2] <= lamp_scheme_ff;
          rd_data_ff[`PMS_EXT_MCO]         <= mco_ff;
        end
        default: rd_data_ff <= 16'h0000;
      endcase
    end
  end

  // Free-running blink; a slow lamp rate needs no phase alignment to activity.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      blink_cnt_ff <= 32'h0;
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
      blink_cnt_ff <= 32'h0;
      blink_ff     <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  assign is10   = speed_i == PMS_SPD_10;
  assign is100  = speed_i == PMS_SPD_100;
  assign is1000 = speed_i == PMS_SPD_1000;

  always_comb begin
    nxt_lamp      = '0;
    nxt_oe        = '0;
    nxt_oe.act    = duplex_done_i;
    nxt_oe.gig    = link_up_i;
    nxt_oe.fast   = link_up_i;
    nxt_oe.slow   = link_up_i;
    unique case (lamp_scheme_ff)
      2'h1, 2'h2: begin
        if (lamp_scheme_ff == 2'h1) begin
          nxt_lamp.fast = is100 | is10;
          nxt_lamp.gig  = is1000 | is10;
        end else begin
          nxt_lamp.fast = is1000 | is10;
          nxt_lamp.gig  = is100 | is10;
        end
        if (lamp_scheme_ff == 2'h2 && collision_i) begin
          nxt_lamp.slow = 1'b1;
          nxt_lamp.act  = 1'b1;
        end else if (activity_i) begin
          nxt_lamp.slow = full_duplex_i & ~blink_ff;
          nxt_lamp.act  = blink_ff;
        end else begin
          nxt_lamp.slow = full_duplex_i;
          nxt_lamp.act  = 1'b0;
        end
      end
      2'h3: begin
        nxt_lamp.gig  = is1000 & (~activity_i | blink_ff);
        nxt_lamp.fast = is100 & (~activity_i | blink_ff);
        nxt_lamp.slow = is10 & (~activity_i | blink_ff);
        nxt_lamp.act  = full_duplex_i;
      end
      2'h0: nxt_lamp = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lamp_o    <= '0;
      lamp_oe_o <= '0;
    end else begin
      lamp_o    <= nxt_lamp;
      lamp_oe_o <= nxt_oe;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_done_o <= 1'b0;
    end else begin
      cfg_done_o <= st_ff == PMS_ST_RUN;
    end
  end

  assign bctl_o          = bctl_ff;
  assign adv_o           = adv_ff;
  assign gig_o           = gig_ff;
  assign mac_clock_off_o = mco_ff;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  AST_MODE_FORCED: assert property (
    st_ff == PMS_ST_LATCH && !pin_hi[0] |=> op_mode_field_ff == {3'h0, $past(pin_lo)}
  ) else $error("forced mode not latched from lower pin");

  AST_MODE_AN: assert property (
    st_ff == PMS_ST_LATCH && pin_hi == 2'h3 && pin_lo == 2'h1 |=> op_mode_field_ff == 5'h04 && mco_ff
  ) else $error("negotiating mode code wrong");

  AST_MCO: assert property (
    st_ff == PMS_ST_LATCH |=> mco_ff == $past(pin_hi[1])
  ) else $error("mac clock bit not from upper pin");

  AST_ORDER: assert property (
    st_ff == PMS_ST_APPLY |-> $past(st_ff) == PMS_ST_LATCH ##1 st_ff == PMS_ST_RUN
  ) else $error("defaults not applied after latch");

  AST_NO_RELATCH: assert property (
    st_ff == PMS_ST_RUN && req.wr |=> st_ff == PMS_ST_RUN && mco_ff == $past(mco_ff) || $past(req.addr) == `PMS_REG_EXT
  ) else $error("write reconfigured the device");

  AST_FORCED_DEF: assert property (
    st_ff == PMS_ST_APPLY && op_mode_field_ff == 5'h03 |=> bctl_ff[13] && !bctl_ff[12] && bctl_ff[8] && !bctl_ff[6] && gig_ff[9:8] == 2'h0 && adv_ff == $past(adv_ff)
  ) else $error("forced mode defaults wrong");

  AST_AN100_DEF: assert property (
    st_ff == PMS_ST_APPLY && op_mode_field_ff == 5'h04 |=> adv_ff[8:5] == 4'h4 && bctl_ff[12] && bctl_ff[13] && gig_ff[9:8] == 2'h0
  ) else $error("mode 00100 defaults wrong");

  AST_MASTER_DEF: assert property (
    st_ff == PMS_ST_APPLY && op_mode_field_ff == 5'h0A |=> gig_ff[12:8] == 5'h1F && adv_ff[8:5] == 4'hF && bctl_ff[6]
  ) else $error("master mode defaults wrong");

  AST_ACT_OE: assert property (
    duplex_done_i && !link_up_i |=> lamp_oe_o.act && !lamp_oe_o.gig
  ) else $error("duplex lamp not driven before link");

  AST_SPEED_OE: assert property (
    !link_up_i [*2] |=> !lamp_oe_o.gig && !lamp_oe_o.fast && !lamp_oe_o.slow
  ) else $error("speed lamp driven without link");

  AST_SCHEME2: assert property (
    lamp_scheme_ff == 2'h2 && speed_i == PMS_SPD_1000 |=> lamp_o.fast && !lamp_o.gig
  ) else $error("scheme 2 gigabit lamp wrong");

  AST_NO_COL1: assert property (
    lamp_scheme_ff == 2'h1 && collision_i && !activity_i |=> lamp_o.slow == $past(full_duplex_i) && !lamp_o.act
  ) else $error("scheme 1 showed collision");

endmodule : pms_mode_lamp_ctl

// ---- test/pms_board.sv ----
// Board around the device: strap ties, the pulled-up management line and the lamps.
module pms_board import pms_pkg::*; (
  input  wire logic [1:0] tie_hi_i,  // Upper pin tie: 0 GND, 1 fast lamp, 2 gig lamp, 3 VDD.
  input  wire logic [1:0] tie_lo_i,  // Lower pin tie, same coding.
  input  wire logic       mgr_oe_i,  // Manager drives the data line.
  input  wire logic       mgr_bit_i, // Manager data bit.
  input  wire logic       dev_oe_i,  // Device drives the data line.
  input  wire logic       dev_bit_i, // Device data bit.
  input  wire pms_lamp_s  lamp_i,    // Lamp levels.
  input  wire pms_lamp_s  lamp_oe_i, // Lamp drive enables.
  output logic      [1:0] pin_hi_o,  // Upper pin code seen by the device.
  output logic      [1:0] pin_lo_o,  // Lower pin code seen by the device.
  output logic            mdio_o,    // Resolved data line.
  output logic      [3:0] lit_o      // Lamps that actually glow.
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pin_hi_o = tie_hi_i;
  assign pin_lo_o = tie_lo_i;
  // A released line floats up on its pull-up rather than keeping the last bit.
  assign mdio_o = dev_oe_i ? dev_bit_i : (mgr_oe_i ? mgr_bit_i : 1'b1);
  // An undriven lamp stays dark whatever level the pad holds.
  assign lit_o = lamp_i & lamp_oe_i;
endmodule : pms_board

// ---- test/pms_mode_lamp_ctl_bench.sv ----
`include "pms_params.svh"
module pms_mode_lamp_ctl_bench import pms_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i, srst_i, mdc, mgr_oe, mgr_bit, link_up, ddone, full, act, coll;
  logic [1:0]  tie_hi, tie_lo, pin_hi, pin_lo, h, l, sc;
  logic [4:0]  m;
  logic        mdio_w, mdio_o, mdio_oe, mco, cfg_done, f, g;
  pms_speed_e  speed;
  pms_lamp_s   lamp, lamp_oe;
  logic [3:0]  lit;
  logic [15:0] bctl, adv, gig, rd, eb, ea, eg;
  int          fails, num_checks, cyc, ones, bad;

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  pms_mode_lamp_ctl #(.PHY_ADDR(5'h00), .BLINK_CYC(8)) dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .mode_pin_hi_i(pin_hi), .mode_pin_lo_i(pin_lo),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .link_up_i(link_up),
    .speed_i(speed), .duplex_done_i(ddone), .full_duplex_i(full), .activity_i(act),
    .collision_i(coll), .lamp_o(lamp), .lamp_oe_o(lamp_oe), .bctl_o(bctl), .adv_o(adv),
    .gig_o(gig), .mac_clock_off_o(mco), .cfg_done_o(cfg_done));

  pms_board board (
    .tie_hi_i(tie_hi), .tie_lo_i(tie_lo), .mgr_oe_i(mgr_oe), .mgr_bit_i(mgr_bit),
    .dev_oe_i(mdio_oe), .dev_bit_i(mdio_o), .lamp_i(lamp), .lamp_oe_i(lamp_oe),
    .pin_hi_o(pin_hi), .pin_lo_o(pin_lo), .mdio_o(mdio_w), .lit_o(lit));

  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      $display("Error at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  // Each management clock phase lasts eight system clocks, well past the pin filter.
  task automatic mbit(input logic b, input logic oe);
    mgr_bit = b;
    mgr_oe  = oe;
    mdc     = 1'b0;
    tick(8);
    mdc = 1'b1;
    tick(8);
  endtask : mbit

  task automatic mframe(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rdv);
    logic [31:0] fr;
    fr  = {2'b01, op, 5'h00, ra, 2'b10, wd};
    rdv = 16'h0000;
    for (int i = 0; i < 32; i++)
      mbit(1'b1, 1'b1);
    for (int i = 0; i < 32; i++) begin
      mbit(fr[31-i], !(op == 2'b10 && i >= 14));
      if (op == 2'b10 && i == 14)
        chk({15'h0, mdio_oe}, 16'h0001, "turnaround drive");
      if (op == 2'b10 && i >= 15 && i <= 30)
        rdv[30-i] = mdio_w;
    end
    mgr_oe  = 1'b1;
    mgr_bit = 1'b1;
    mdc     = 1'b0;
    tick(8);
  endtask : mframe

  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    tie_hi = hi;
    tie_lo = lo;
    srst_i = 1'b1;
    tick(3);
    srst_i = 1'b0;
    for (int k = 0; k < 50 && cfg_done !== 1'b1; k++)
      tick(1);
    chk({15'h0, cfg_done}, 16'h0001, "config done");
  endtask : do_reset

  task automatic lamps(input logic [3:0] e, input logic [3:0] eo, input string w);
    tick(3);
    chk({12'h0, lamp}, {12'h0, e}, w);
    chk({12'h0, lamp_oe}, {12'h0, eo}, w);
  endtask : lamps

  initial begin
    srst_i = 1'b1; mdc = 1'b0; mgr_oe = 1'b1; mgr_bit = 1'b1; tie_hi = 2'h0; tie_lo = 2'h0;
    link_up = 1'b0; ddone = 1'b0; full = 1'b0; act = 1'b0; coll = 1'b0; speed = PMS_SPD_10;
    for (int c = 0; c < 16; c++) begin
      h = c[3:2];
      l = c[1:0];
      m = !h[0] ? {3'h0, l} : (l == 2'h0 ? 5'h07 : l == 2'h1 ? 5'h04 : l == 2'h2 ? 5'h09 : 5'h0A);
      eb = m == 5'h00 ? 16'h0000 : m == 5'h01 ? 16'h0100 : m == 5'h02 ? 16'h2000 :
           m == 5'h03 ? 16'h2100 : m == 5'h04 ? 16'h3000 : 16'h1040;
      ea = m == 5'h04 ? 16'h0081 : 16'h01E1;
      eg = m == 5'h07 ? 16'h0300 : m == 5'h09 ? 16'h1300 : m == 5'h0A ? 16'h1F00 : 16'h0000;
      do_reset(h, l);
      mframe(2'b10, `PMS_REG_EXT, 16'h0000, rd);
      chk(rd, {m, 3'h0, 2'h3, 2'h0, h[1], 3'h0}, "ext reg");
      chk({15'h0, mco}, {15'h0, h[1]}, "mac clock");
      chk(bctl, eb, "basic control");
      chk(adv, ea, "advertise");
      chk(gig, eg, "gig control");
    end
    mframe(2'b10, `PMS_REG_BCTL, 16'h0000, rd);
    chk(rd, 16'h1040, "bctl read");
    tie_hi = 2'h0;
    tie_lo = 2'h1;
    mframe(2'b01, `PMS_REG_EXT, 16'h0040, rd);
    mframe(2'b01, `PMS_REG_BCTL, 16'h9040, rd);
    tick(4);
    chk(bctl, 16'h1040, "soft reset bctl");
    chk(adv, 16'h01E1, "soft reset adv");
    chk(gig, 16'h1F00, "soft reset gig");
    mframe(2'b10, `PMS_REG_EXT, 16'h0000, rd);
    chk(rd, 16'h0040, "ext readback");
    mframe(2'b01, 5'h1F, 16'hFFFF, rd);
    mframe(2'b10, 5'h1F, 16'h0000, rd);
    chk(rd, 16'h0000, "unmapped read");
    ddone = 1'b1;
    full  = 1'b1;
    tick(3);
    chk({12'h0, lamp_oe}, 16'h0001, "duplex before link");
    chk({12'h0, lit[3:1]}, 16'h0000, "dark speed lamps");
    link_up = 1'b1;
    for (int s = 1; s < 3; s++) begin
      sc = s[1:0];
      mframe(2'b01, `PMS_REG_EXT, {8'h00, sc, 6'h00}, rd);
      for (int sp = 0; sp < 3; sp++) begin
        speed = pms_speed_e'(sp[1:0]);
        f = sp == 0 || sp == (s == 1 ? 1 : 2);
        g = sp == 0 || sp == (s == 1 ? 2 : 1);
        lamps({g, f, 2'b10}, 4'hF, "two colour lamps");
      end
      full = 1'b0;
      coll = 1'b1;
      speed = PMS_SPD_100;
      lamps(s == 2 ? 4'hB : 4'h4, 4'hF, "collision");
      coll = 1'b0;
      full = 1'b1;
    end
    mframe(2'b01, `PMS_REG_EXT, 16'h0040, rd);
    act  = 1'b1;
    ones = 0;
    bad  = 0;
    tick(2);
    for (int k = 0; k < 40; k++) begin
      tick(1);
      ones += lamp.act;
      bad += (lamp.slow === lamp.act);
    end
    chk({15'h0, ones > 5 && ones < 35}, 16'h0001, "activity blink");
    chk(bad[15:0], 16'h0000, "duplex pair alternates");
    // Half duplex with activity: the full-duplex colour stays dark while the other blinks.
    full = 1'b0;
    tick(2);
    ones = 0;
    bad  = 0;
    for (int k = 0; k < 16; k++) begin
      tick(1);
      ones += lamp.act;
      bad += lamp.slow;
    end
    chk({15'h0, ones > 0 && ones < 16}, 16'h0001, "half duplex blink");
    chk(bad[15:0], 16'h0000, "half duplex pair off");
    full = 1'b1;
    act = 1'b0;
    mframe(2'b01, `PMS_REG_EXT, 16'h00C0, rd);
    for (int sp = 0; sp < 3; sp++) begin
      speed = pms_speed_e'(sp[1:0]);
      lamps({sp == 2, sp == 1, sp == 0, 1'b1}, 4'hF, "four lamps");
    end
    mframe(2'b01, `PMS_REG_EXT, 16'h0000, rd);
    lamps(4'h0, 4'hF, "scheme off");
    link_up = 1'b0;
    ddone   = 1'b0;
    lamps(4'h0, 4'h0, "unresolved");
    stop_test();
  end
endmodule : pms_mode_lamp_ctl_bench
